// ---- core/spimsp_pkg.sv ----
// package: register map, field positions, encodings and struct types
package spimsp_pkg;
  // register indices on the plain register port
  localparam logic [1:0] SPIMSP_CTRL_ADDR = 2'h0;  // serial_port_control
  localparam logic [1:0] SPIMSP_STAT_ADDR = 2'h1;  // serial_port_status
  localparam logic [1:0] SPIMSP_DATA_ADDR = 2'h2;  // serial_port_data
  // control field positions
  localparam int CTL_IE   = 7;  // port_interrupt_enable
  localparam int CTL_SE   = 6;  // port_system_enable
  localparam int CTL_MS   = 4;  // master_select
  localparam int CTL_POL  = 3;  // clock_idle_polarity
  localparam int CTL_PHA  = 2;  // clock_phase_select
  localparam int CTL_RHI  = 1;  // rate_select_high
  localparam int CTL_RLO  = 0;  // rate_select_low
  // status field positions
  localparam int STA_TC   = 7;  // transfer_complete_flag
  localparam int STA_WC   = 6;  // write_collision_flag
  localparam int STA_MF   = 4;  // mode_fault_flag
  localparam logic [7:0] SPIMSP_CTRL_RST = 8'h00;
  localparam logic [7:0] SPIMSP_ZERO8    = 8'h00;
  // bits per character
  localparam logic [3:0] SPIMSP_NBITS    = 4'h8;
  // last half-period counts (half period minus one bus clock) for divides 2, 4, 16, 32
  localparam logic [3:0] SPIMSP_HALF_D2  = 4'h0;
  localparam logic [3:0] SPIMSP_HALF_D4  = 4'h1;
  localparam logic [3:0] SPIMSP_HALF_D16 = 4'h7;
  localparam logic [3:0] SPIMSP_HALF_D32 = 4'hf;
  // register request bundle
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } spimsp_req_t;
  // link pins (two-way pins as in, out, enable)
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spimsp_pins_t;
endpackage : spimsp_pkg

// ---- core/spimsp_rate.sv ----
// bit-rate divider: one-cycle half-period enable pulses
`timescale 1ns/1ps
module spimsp_rate (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [1:0] rate,
  output logic            tick
);
  import spimsp_pkg::*;
  logic [3:0] cnt_r;   // bus clocks within current half period
  logic [3:0] limit;   // last count of a half period

  // choose half period from rate bits
  always_comb begin
    case (rate)
      2'b00:   limit = SPIMSP_HALF_D2;
      2'b01:   limit = SPIMSP_HALF_D4;
      2'b10:   limit = SPIMSP_HALF_D16;
      default: limit = SPIMSP_HALF_D32;
    endcase
  end

  assign tick = run && (cnt_r == limit);

  // count while a transfer runs, restart otherwise
  always_ff @(posedge clk) begin
    if (!rst_n || !run || tick) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule // spimsp_rate

// ---- core/spimsp_top.sv ----
// serial port block: master/slave shifter with control/status/data registers
// Operation
// - select low while master sets mode fault
// - phase 1 select may stay low
// - full duplex; complete flag set per byte
// - write during transfer dropped, collision flag set
// - master writes start exactly eight clocks
// - slave shifts in, copies to read buffer
// - slave write loads shifter, shifts on clocks
// - complete flag with enable raises interrupt
// - enable bit on/off; master bit selects mode
// - master clock idles at polarity level
// - phase 0 starts on select fall
// - rate bits divide clock 2,4,16,32
// - complete flag cleared by status read, data access
// - data writes blocked until status read
// - collision window depends on phase
// - collision flag cleared by status read, data access
// - unused status bits read zero
// - mode fault interrupts, clears enable and master
// - mode fault cleared by status read, control write
// - overrun loses new byte, buffer kept
// - slave output released when not selected
// - most significant bit first
// - master data leads sampling edge half period
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module spimsp_top
  import spimsp_pkg::*;
(
  input  wire logic               CLK_SYS,
  input  wire logic               RSTN,
  input  wire spimsp_pkg::spimsp_req_t REQ,
  output logic [7:0]              RDATA,
  input  wire logic               SCK_I,
  input  wire logic               MOSI_I,
  input  wire logic               MISO_I,
  input  wire logic               SS_N_I,
  output spimsp_pkg::spimsp_pins_t PINS,
  output logic                    IRQ
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,  // no transfer
    ST_LEAD = 3'b010,  // first half period, data set up
    ST_TRAIL = 3'b100  // second half period
  } spimsp_st_t;

  logic [7:0] ctrl_r;       // control register
  logic       tc_r;         // transfer complete flag
  logic       wc_r;         // write collision flag
  logic       mf_r;         // mode fault flag
  logic       tc_seen_r;    // status read saw complete flag
  logic       wc_seen_r;    // status read saw collision flag
  logic       mf_seen_r;    // status read saw mode fault
  logic [7:0] shift_r;      // shift register
  logic [7:0] rbuf_r;       // read buffer
  logic [3:0] bits_r;       // bits shifted so far
  logic       sck_d_r;      // last slave clock sample
  logic       ss_d_r;       // last select sample
  logic       sbusy_r;      // slave transfer in progress
  logic       mosi_r;       // master output bit
  logic       miso_r;       // slave output bit
  logic       sck_r;        // master clock level before polarity
  spimsp_st_t st_r;         // master state
  logic       tick;         // half-period enable
  logic       master, en, pha, pol;
  logic       mbusy, busy;
  logic       wr_ctrl, wr_data, rd_stat, acc_data;
  logic       s_lead, s_trail, sck_eff, ss_sel;
  logic       byte_done;
  logic       m_lead, m_trail, samp, drive, din, last, mstop, wr_ok;
  logic [7:0] sh_in, sh_hold;  // shifter plus new bit; value a collision keeps
  logic [7:0] status;

  assign en      = ctrl_r[CTL_SE];
  assign master  = ctrl_r[CTL_MS];
  assign pha     = ctrl_r[CTL_PHA];
  assign pol     = ctrl_r[CTL_POL];
  assign wr_ctrl = REQ.wr && (REQ.addr == SPIMSP_CTRL_ADDR);
  assign wr_data = REQ.wr && (REQ.addr == SPIMSP_DATA_ADDR);
  assign rd_stat = REQ.rd && (REQ.addr == SPIMSP_STAT_ADDR);
  assign acc_data = (REQ.wr || REQ.rd) && (REQ.addr == SPIMSP_DATA_ADDR);
  assign mbusy   = (st_r != ST_IDLE);
  assign busy    = master ? mbusy : sbusy_r;

  // unused status bits tied to zero
  always_comb begin
    status = SPIMSP_ZERO8;
    status[STA_TC] = tc_r;
    status[STA_WC] = wc_r;
    status[STA_MF] = mf_r;
  end

  // divider for master bit rate
  spimsp_rate u_rate (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .run   (mbusy),
    .rate  ({ctrl_r[CTL_RHI], ctrl_r[CTL_RLO]}),
    .tick  (tick)
  );

  // slave clock edges; phase 0 clock is clock OR select
  assign sck_eff = (SCK_I ^ pol) | (!pha & SS_N_I);
  assign ss_sel  = !SS_N_I;
  assign s_lead  = ss_sel && !master && en && sck_eff && !sck_d_r;
  assign s_trail = ss_sel && !master && en && !sck_eff && sck_d_r;

  // phase 0 samples on the leading edge and drives on the trailing one,
  // phase 1 the other way round, in both master and slave mode
  assign m_lead  = (st_r == ST_LEAD) && tick;
  assign m_trail = (st_r == ST_TRAIL) && tick;
  assign samp    = master ? (pha ? m_trail : m_lead)
                          : (pha ? s_trail : s_lead);
  assign drive   = master ? (pha ? m_lead : m_trail)
                          : (pha ? s_lead : s_trail);
  assign din     = master ? MISO_I : MOSI_I;
  assign last    = (bits_r == SPIMSP_NBITS - 4'h1);
  assign sh_in   = {shift_r[6:0], din};
  assign sh_hold = samp ? sh_in : shift_r;
  // phase 0 master stops on the trail after the count wrapped
  assign mstop   = pha ? last : (bits_r == 4'h0);
  // a write after the status read that saw the flag may land
  assign wr_ok   = wr_data && !busy && !(tc_r && !tc_seen_r);
  // byte finished on its eighth sampling edge
  assign byte_done = samp && last;

  // control register, mode fault forces slave and disabled
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ctrl_r <= SPIMSP_CTRL_RST;
    end else if (en && master && !SS_N_I) begin
      ctrl_r[CTL_SE] <= 1'b0;
      ctrl_r[CTL_MS] <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_r <= REQ.wdata;
    end
  end

  // mode fault flag; set wins over clear
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      mf_r <= 1'b0;
      mf_seen_r <= 1'b0;
    end else if (en && master && !SS_N_I) begin
      mf_r <= 1'b1;
      mf_seen_r <= 1'b0;
    end else if (wr_ctrl && mf_seen_r) begin
      mf_r <= 1'b0;
      mf_seen_r <= 1'b0;
    end else if (rd_stat && mf_r) begin
      mf_seen_r <= 1'b1;
    end
  end

  // complete flag; status read then data access clears
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      tc_r <= 1'b0;
      tc_seen_r <= 1'b0;
    end else if (byte_done) begin
      tc_r <= 1'b1;
      tc_seen_r <= 1'b0;
    end else if (acc_data && tc_seen_r) begin
      tc_r <= 1'b0;
      tc_seen_r <= 1'b0;
    end else if (rd_stat && tc_r) begin
      tc_seen_r <= 1'b1;
    end
  end

  // collision flag; write during transfer
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      wc_r <= 1'b0;
      wc_seen_r <= 1'b0;
    end else if (wr_data && busy) begin
      wc_r <= 1'b1;
      wc_seen_r <= 1'b0;
    end else if (acc_data && wc_seen_r) begin
      wc_r <= 1'b0;
      wc_seen_r <= 1'b0;
    end else if (rd_stat && wc_r) begin
      wc_seen_r <= 1'b1;
    end
  end

  // slave edge tracking and transfer window
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      sck_d_r <= 1'b1;
      ss_d_r  <= 1'b1;
      sbusy_r <= 1'b0;
    end else begin
      sck_d_r <= sck_eff;
      ss_d_r  <= SS_N_I;
      if (master || !en || SS_N_I) begin
        sbusy_r <= 1'b0;                       // phase 0 ends on select rise
      end else if (!pha && ss_d_r) begin
        sbusy_r <= 1'b1;
      end else if (pha && s_lead) begin
        sbusy_r <= 1'b1;
      end else if (pha && byte_done) begin
        sbusy_r <= 1'b0;
      end
    end
  end

  // master sequencer: idle, lead half, trail half
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || !en || !master) begin
      st_r <= ST_IDLE;
      sck_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          sck_r <= 1'b0;
          if (wr_ok) begin
            st_r <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            sck_r <= 1'b1;
            st_r <= ST_TRAIL;
          end
        end
        ST_TRAIL: begin
          if (tick) begin
            sck_r <= 1'b0;
            st_r <= mstop ? ST_IDLE : ST_LEAD;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // shift register, bit count and outputs, msb first
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      shift_r <= SPIMSP_ZERO8;
      bits_r  <= 4'h0;
      mosi_r  <= 1'b0;
      miso_r  <= 1'b0;
    end else if (wr_ok) begin
      shift_r <= REQ.wdata;
      bits_r  <= 4'h0;
      mosi_r  <= REQ.wdata[7];
      miso_r  <= REQ.wdata[7];
    end else if (!master && !pha && SS_N_I) begin
      bits_r <= 4'h0;
    end else if (samp) begin
      shift_r <= sh_in;
      bits_r  <= last ? 4'h0 : bits_r + 4'h1;
    end else if (drive) begin
      mosi_r  <= shift_r[7];
      miso_r  <= shift_r[7];
    end
  end

  // read buffer; overrun keeps old contents
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      rbuf_r <= SPIMSP_ZERO8;
    end else if (byte_done && !tc_r) begin
      rbuf_r <= sh_in;
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      RDATA <= SPIMSP_ZERO8;
    end else if (REQ.rd) begin
      if (REQ.addr == SPIMSP_CTRL_ADDR) begin
        RDATA <= ctrl_r;
      end else if (REQ.addr == SPIMSP_STAT_ADDR) begin
        RDATA <= status;
      end else if (REQ.addr == SPIMSP_DATA_ADDR) begin
        RDATA <= rbuf_r;
      end else begin
        RDATA <= SPIMSP_ZERO8;
      end
    end else begin
      RDATA <= SPIMSP_ZERO8;
    end
  end

  // pin drive
  always_comb begin
    PINS.sck_o   = sck_r ^ pol;
    PINS.sck_oe  = en && master;
    PINS.mosi_o  = mosi_r;
    PINS.mosi_oe = en && master;
    PINS.miso_o  = miso_r;
    PINS.miso_oe = en && !master && !SS_N_I;
  end

  assign IRQ = ctrl_r[CTL_IE] && (tc_r || mf_r);

  // checks
  property p_mode_fault_flag;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (en && master && !SS_N_I) |=> (mf_r && !en && !master);
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault missed");

  property p_irq;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (tc_r && ctrl_r[CTL_IE]) |-> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_write_collision_flag;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (wr_data && busy) |=> (wc_r && shift_r == $past(sh_hold));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision wrong");

  property p_idle_sck;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (master && en && !mbusy) |-> (PINS.sck_o == pol);
  endproperty
  a_idle_sck: assert property (p_idle_sck) else $error("sck idle");

  property p_tc;
    @(posedge CLK_SYS) disable iff (!RSTN)
    byte_done |=> tc_r;
  endproperty
  a_tc: assert property (p_tc) else $error("complete not set");

  property p_tc_hold;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (tc_r && !tc_seen_r && !byte_done) |=> tc_r;
  endproperty
  a_tc_hold: assert property (p_tc_hold) else $error("early clear");

  property p_ovr;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (byte_done && tc_r) |=> $stable(rbuf_r);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun wrote");

  property p_miso;
    @(posedge CLK_SYS) disable iff (!RSTN)
    SS_N_I |-> !PINS.miso_oe;
  endproperty
  a_miso: assert property (p_miso) else $error("miso driven");

  property p_stat0;
    @(posedge CLK_SYS) disable iff (!RSTN)
    REQ.rd && REQ.addr == SPIMSP_STAT_ADDR |=> RDATA[5] == 1'b0
      && RDATA[3:0] == 4'h0;
  endproperty
  a_stat0: assert property (p_stat0) else $error("reserved bits");
endmodule // spimsp_top

// ---- verif/spimsp_far_slave.sv ----
// far-side serial slave model used while the block is master
`timescale 1ns/1ps
module spimsp_far_slave #(
  parameter int LAG = 0  // output delay in ns, models a slow slave
) (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       clock_idle_polarity,
  input  wire logic       clock_phase_select,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  logic [7:0] sh;             // outgoing shifter
  logic       q;              // undelayed output level
  wire        lead = sck ^ clock_idle_polarity;  // polarity removed from the clock
  initial begin
    sh = 8'h00;
    q  = 1'b0;
    rx = 8'h00;
  end
  assign #(LAG) miso = q;
  // select loads the byte; phase 0 shows the first bit at once
  always @(negedge sel_n) begin
    sh = tx;
    if (!clock_phase_select) q = sh[7];
  end
  // released line shows the inverse so stale data never looks valid
  always @(posedge sel_n) q = ~q;
  // leading edge: phase 0 samples, phase 1 drives
  always @(posedge lead) if (!sel_n) begin
    if (clock_phase_select) q = sh[7];
    else rx = {rx[6:0], mosi};
  end
  // trailing edge: phase 1 samples; both shift on
  always @(negedge lead) if (!sel_n) begin
    if (clock_phase_select) rx = {rx[6:0], mosi};
    sh = {sh[6:0], 1'b0};
    if (!clock_phase_select) q = sh[7];
  end
endmodule // spimsp_far_slave

// ---- verif/spimsp_tb_top.sv ----
// testbench: register tasks, master and slave transfers, faults
`timescale 1ns/1ps
module spimsp_tb_top;
  import spimsp_pkg::*;
  logic         clk_sys, rstn, ss_n, b_sck, b_mosi;  // bench-driven pins
  logic         f_sel_n, f_pol, f_pha, far_miso, irq;
  logic [7:0]   rdata, f_tx, f_rx, ctl, seen;
  spimsp_req_t  req;                   // register request
  spimsp_pins_t pins;                  // link outputs
  int           num_errors, checks_done, cycles, edges, gap, last_gap;
  int           i, base;
  logic         sck_prev;
  logic [7:0]   txs [4] = '{8'ha5, 8'h0f, 8'hc6, 8'h81};  // far bytes
  logic [7:0]   wds [4] = '{8'h5a, 8'hf0, 8'h39, 8'h7e};  // our bytes
  int           divs [4] = '{2, 4, 16, 32};
  // wire levels resolved from the block's output enables
  wire sck_w  = pins.sck_oe ? pins.sck_o : b_sck;
  wire mosi_w = pins.mosi_oe ? pins.mosi_o : b_mosi;
  wire miso_w = pins.miso_oe ? pins.miso_o : far_miso;
  spimsp_top DUT (.CLK_SYS(clk_sys), .RSTN(rstn), .REQ(req), .RDATA(rdata),
    .SCK_I(sck_w), .MOSI_I(mosi_w), .MISO_I(miso_w), .SS_N_I(ss_n),
    .PINS(pins), .IRQ(irq));
  spimsp_far_slave #(.LAG(3)) FAR (.sck(sck_w), .mosi(mosi_w),
    .sel_n(f_sel_n), .clock_idle_polarity(f_pol), .clock_phase_select(f_pha), .tx(f_tx),
    .miso(far_miso), .rx(f_rx));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // compare tasks: byte, bit, count
  task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk1(input string w, input logic e, input logic g);
    chk8(w, {7'h00, e}, {7'h00, g});
  endtask
  task automatic chkn(input string w, input int e, input int g);
    checks_done++;
    if (g != e) begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", w, e, g);
    end
  endtask
  // register port: one-cycle strobes, read data the cycle after
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  task automatic rd_chk(input string w, input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 chk8(w, e, rdata);
  endtask
  // bench as master, phase 1 polarity 0; clock high five bus clocks, low four
  task automatic sl_byte(input logic [7:0] o, output logic [7:0] s);
    for (int k = 7; k >= 0; k--) begin
      @(posedge clk_sys);
      b_sck <= 1'b1;
      b_mosi <= o[k];
      repeat (4) @(posedge clk_sys);
      #1 s[k] = miso_w;
      @(posedge clk_sys);
      b_sck <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    b_mosi <= ~o[0];
  endtask
  // cycle limit and serial clock edge monitor
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 6000) begin
      num_errors++;
      $display("mismatch run length expected 6000 seen more");
      finish_test();
    end
    if (pins.sck_o !== sck_prev) begin
      edges++;
      last_gap = gap;
      gap = 1;
    end else gap++;
    sck_prev = pins.sck_o;
  end
  initial begin
    {rstn, b_sck, b_mosi, f_pol, f_pha, sck_prev} = 6'h00;
    {ss_n, f_sel_n} = 2'h3;
    req = '0;
    f_tx = 8'h00;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_chk("ctrl reset", SPIMSP_CTRL_ADDR, 8'h00);
    rd_chk("stat reset", SPIMSP_STAT_ADDR, 8'h00);
    rd_chk("data reset", SPIMSP_DATA_ADDR, 8'h00);
    rd_chk("unmapped", 2'h3, 8'h00);
    chk1("irq reset", 1'b0, irq);
    chk1("sck enable", 1'b0, pins.sck_oe);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      ctl = {i == 3, 2'h2, 1'b1, i[0], i[1], i[1:0]};
      f_pol <= i[0];
      f_pha <= i[1];
      f_tx <= txs[i];
      wr_reg(SPIMSP_CTRL_ADDR, ctl);
      repeat (3) @(posedge clk_sys);
      chk1("sck idle", i[0], pins.sck_o);
      base = edges;
      f_sel_n <= 1'b0;
      wr_reg(SPIMSP_DATA_ADDR, wds[i]);
      if (i == 1) wr_reg(SPIMSP_DATA_ADDR, 8'hff);
      for (int k = 0; k < 2000 && edges < base + 16; k++) @(posedge clk_sys);
      repeat (4) @(posedge clk_sys);
      wr_reg(SPIMSP_DATA_ADDR, 8'h3c);
      repeat (40) @(posedge clk_sys);
      chkn("sck edges", 16, edges - base);
      chkn("half period", divs[i] / 2, last_gap);
      chk1("sck idle after", i[0], pins.sck_o);
      f_sel_n <= 1'b1;
      rd_chk("stat done", SPIMSP_STAT_ADDR, (i == 1) ? 8'hc0 : 8'h80);
      chk1("irq done", i == 3, irq);
      rd_chk("data in", SPIMSP_DATA_ADDR, txs[i]);
      rd_chk("stat clear", SPIMSP_STAT_ADDR, 8'h00);
      chk8("far rx", wds[i], f_rx);
      $display("test master mode %0d done", i);
    end
    wr_reg(SPIMSP_CTRL_ADDR, 8'hd0);
    @(posedge clk_sys);
    ss_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ss_n <= 1'b1;
    rd_chk("stat fault", SPIMSP_STAT_ADDR, 8'h10);
    chk1("irq fault", 1'b1, irq);
    rd_chk("ctrl fault", SPIMSP_CTRL_ADDR, 8'h80);
    chk1("sck enable fault", 1'b0, pins.sck_oe);
    wr_reg(SPIMSP_CTRL_ADDR, 8'h00);
    rd_chk("stat fault clr", SPIMSP_STAT_ADDR, 8'h00);
    chk1("irq clear", 1'b0, irq);
    $display("test mode fault done");
    wr_reg(SPIMSP_CTRL_ADDR, 8'h47);
    wr_reg(SPIMSP_DATA_ADDR, 8'hb4);
    repeat (2) @(posedge clk_sys);
    chk1("miso off", 1'b0, pins.miso_oe);
    ss_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk1("miso on", 1'b1, pins.miso_oe);
    sl_byte(8'h6d, seen);
    chk8("slave out", 8'hb4, seen);
    sl_byte(8'h12, seen);
    ss_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk1("miso off after", 1'b0, pins.miso_oe);
    rd_chk("stat slave", SPIMSP_STAT_ADDR, 8'h80);
    rd_chk("slave data", SPIMSP_DATA_ADDR, 8'h6d);
    rd_chk("stat slave clr", SPIMSP_STAT_ADDR, 8'h00);
    $display("test slave done");
    wr_reg(SPIMSP_CTRL_ADDR, 8'h43);
    wr_reg(SPIMSP_DATA_ADDR, 8'h96);
    ss_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    sl_byte(8'hc3, seen);
    chk8("slave out ph0", 8'h96, seen);
    ss_n <= 1'b1;
    rd_chk("stat ph0", SPIMSP_STAT_ADDR, 8'h80);
    rd_chk("data ph0", SPIMSP_DATA_ADDR, 8'hc3);
    rd_chk("stat ph0 clr", SPIMSP_STAT_ADDR, 8'h00);
    $display("test slave phase 0 done");
    finish_test();
  end
endmodule // spimsp_tb_top
